// file: hdl/fcs_pkg.sv
// Constants and types shared by the flash command and security controller.
package fcs_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_RATIO = 8'h00;
   localparam logic [7:0] OFF_OPT = 8'h04;
   localparam logic [7:0] OFF_CNFG = 8'h08;
   localparam logic [7:0] OFF_PROT = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_CMD = 8'h14;
   localparam logic [7:0] OFF_FADDR = 8'h18;
   localparam logic [7:0] OFF_FDATA = 8'h1C;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int OPT_KEY_EN = 7;
   localparam int OPT_NORED = 6;
   localparam int CNFG_KEY_ACC = 5;
   localparam int PROT_DIS = 0;
   localparam int RATIO_LOADED = 7;
   localparam int STAT_CBEF = 7;
   localparam int STAT_CCF = 6;
   localparam int STAT_PVIOL = 5;
   localparam int STAT_ACCERR = 4;
   localparam int STAT_BLANK = 2;
   localparam int PAGE_MSB = 15;
   localparam int PAGE_LSB = 9;
   // ****************************************
   // Codes and values
   // ****************************************
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
   localparam logic [7:0] CMD_BURST_PROG = 8'h25;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
   localparam logic [15:0] KEY_BASE = 16'hFFB0;
   localparam logic [3:0] KEY_BYTES = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // Command sequence states
   // ****************************************
   typedef enum logic [1:0] {
      FCS_SEQ_IDLE,
      FCS_SEQ_DATA,
      FCS_SEQ_CMD
   } fcs_seq_t;
endpackage

// file: hdl/fcs_key_check.sv
// Backdoor key comparator that checks eight key bytes written in ascending order.
`timescale 1ns/1ps
`default_nettype none
module fcs_key_check (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic byte_we,
   input wire logic [2:0] byte_off,
   input wire logic [7:0] byte_data,
   input wire logic [63:0] key,
   output logic match
);
   typedef struct packed {
      logic [3:0] idx;
      logic ok;
   } fcs_key_state_t;

   fcs_key_state_t r_reg;
   fcs_key_state_t r_next;

   // A byte out of order or wrong spoils the whole entry until the next restart.
   always_comb begin
      r_next = r_reg;
      if (!aresetn) begin
         r_next = '0;
      end else if (restart) begin
         r_next.idx = 4'h0;
         r_next.ok = 1'b1;
      end else if (byte_we) begin
         if (r_reg.idx < fcs_pkg::KEY_BYTES && byte_off == r_reg.idx[2:0] &&
             byte_data == key[{r_reg.idx[2:0], 3'b000} +: 8]) begin
            r_next.idx = r_reg.idx + 4'h1;
         end else begin
            r_next.ok = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      r_reg <= r_next;
   end

   assign match = r_reg.ok & (r_reg.idx == fcs_pkg::KEY_BYTES);
endmodule
`default_nettype wire

// file: hdl/fcs_flash_ctrl.sv
// Flash command, protection and security controller with an AXI4-Lite register slave.
// Behaviour
// - Options register reloads from its nonvolatile copy on every reset.
// - Backdoor key cannot unlock while the options key enable bit is zero.
// - Key bytes count only from secure writes, never from unsecured writes (awprot bit 1 set).
// - Eight matching key bytes in order unlock security until next reset.
// - Options bit 6 set disables vector redirection, clear enables it.
// - Security code 1:0 alone means unsecured; other codes mean secure.
// - While secure, unsecured sources are denied RAM and flash content access.
// - Key unlock or fully blank check sets the security code to 1:0.
// - Key access bit steers key-range writes to comparison or commands.
// - Protection loads from nonvolatile copy, reads freely, ignores program writes.
// - Protect select field bounds unprotected flash; protected targets are refused.
// - Protection disable set leaves every flash block unprotected.
// - Writing one to buffer empty launches; burst transfer to array refreshes it.
// - Only burst program commands queue, and only behind a running burst program.
// - Complete flag shows empty buffer and idle array; writes ignored.
// - Protected target launch is ignored and sets a write-one-clear violation flag.
// - Broken sequence, no clock ratio, or stop mid-command sets access error.
// - Blank flag set by blank check success, cleared on valid launch.
// - Codes 0x05, 0x20, 0x25 are blank check, byte and burst program.
// - Codes 0x40 and 0x41 are page erase and mass erase.
// - Any other command code is rejected with an access error.
// - Program and erase stay disabled until the clock ratio is written.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] nonvolatile_options_copy,
   input wire logic [7:0] nonvolatile_protection_copy,
   input wire logic [63:0] backdoor_key_locations,
   input wire logic dbg_prot_we,
   input wire logic [7:0] dbg_prot_data,
   input wire logic mem_req_unsecured,
   input wire logic array_done,
   input wire logic array_blank,
   input wire logic stop_entry,
   output logic array_start,
   output logic [7:0] array_cmd,
   output logic [15:0] array_addr,
   output logic [7:0] array_data,
   output logic [6:0] array_tick_ratio,
   output logic device_secure,
   output logic vector_redirect_enable,
   output logic mem_access_deny
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      fcs_pkg::fcs_seq_t seq;
      logic aw_held;
      logic [7:0] aw_addr;
      logic aw_nsec;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] opt;
      logic key_acc;
      logic [7:0] prot;
      logic [6:0] ratio;
      logic ratio_written;
      logic [15:0] fl_addr;
      logic [7:0] fl_data;
      logic [7:0] cmd;
      logic buf_empty;
      logic running;
      logic [7:0] run_cmd;
      logic pviol;
      logic accerr;
      logic blank;
      logic start;
      logic [7:0] a_cmd;
      logic [15:0] a_addr;
      logic [7:0] a_data;
   } fcs_state_t;

   fcs_state_t r_reg;
   fcs_state_t r_next;
   logic wr_go;
   logic wr_b0;
   logic key_we;
   logic key_restart;
   logic key_match;
   logic key_unlock;
   logic cmd_valid;
   logic cmd_prot;
   logic launch_try;
   logic launch_ok;
   logic set_acc;
   logic set_pv;
   logic done_blank;
   logic ccf;
   logic in_key_range;
   logic [7:0] st_byte;

   assign ccf = r_reg.buf_empty & ~r_reg.running;
   assign st_byte = {r_reg.buf_empty, ccf, r_reg.pviol, r_reg.accerr, 1'b0, r_reg.blank, 2'b00};
   assign in_key_range = (r_reg.fl_addr[15:3] == fcs_pkg::KEY_BASE[15:3]);
   // Blank check never modifies the array, so protection does not apply to it.
   assign cmd_prot = ~r_reg.prot[fcs_pkg::PROT_DIS] & (r_reg.cmd != fcs_pkg::CMD_BLANK) &
      ((r_reg.cmd == fcs_pkg::CMD_MASS_ERASE) |
       (r_reg.fl_addr[fcs_pkg::PAGE_MSB:fcs_pkg::PAGE_LSB] > r_reg.prot[7:1]));
   assign cmd_valid = (r_reg.cmd == fcs_pkg::CMD_BLANK) | (r_reg.cmd == fcs_pkg::CMD_BYTE_PROG) |
      (r_reg.cmd == fcs_pkg::CMD_BURST_PROG) | (r_reg.cmd == fcs_pkg::CMD_PAGE_ERASE) |
      (r_reg.cmd == fcs_pkg::CMD_MASS_ERASE);

   fcs_key_check u_key (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(key_restart),
      .byte_we(key_we),
      .byte_off(r_reg.fl_addr[2:0]),
      .byte_data(r_reg.w_data[7:0]),
      .key(backdoor_key_locations),
      .match(key_match)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      r_next = r_reg;
      r_next.start = 1'b0;
      wr_go = r_reg.aw_held & r_reg.w_held & ~r_reg.bvalid;
      wr_b0 = wr_go & r_reg.w_strb[0];
      key_we = 1'b0;
      key_restart = 1'b0;
      key_unlock = 1'b0;
      launch_try = 1'b0;
      launch_ok = 1'b0;
      set_acc = 1'b0;
      set_pv = 1'b0;
      done_blank = 1'b0;
      if (!aresetn) begin
         r_next = '0;
         r_next.opt = nonvolatile_options_copy;
         r_next.prot = nonvolatile_protection_copy;
         r_next.buf_empty = 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_held = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
            r_next.aw_nsec = s_axi_awprot[1];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_held = 1'b1;
            r_next.w_data = s_axi_wdata[15:0];
            r_next.w_strb = s_axi_wstrb[1:0];
         end
         if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
         end
         if (wr_go) begin
            r_next.aw_held = 1'b0;
            r_next.w_held = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = fcs_pkg::RESP_OKAY;
            case (r_reg.aw_addr)
               fcs_pkg::OFF_RATIO: begin
                  if (wr_b0) begin
                     r_next.ratio = r_reg.w_data[6:0];
                     r_next.ratio_written = 1'b1;
                  end
               end
               fcs_pkg::OFF_CNFG: begin
                  if (wr_b0) begin
                     r_next.key_acc = r_reg.w_data[fcs_pkg::CNFG_KEY_ACC];
                     key_restart = r_reg.w_data[fcs_pkg::CNFG_KEY_ACC] & ~r_reg.key_acc;
                     key_unlock = r_reg.key_acc & ~r_reg.w_data[fcs_pkg::CNFG_KEY_ACC] &
                        key_match & r_reg.opt[fcs_pkg::OPT_KEY_EN];
                  end
               end
               fcs_pkg::OFF_STAT: begin
                  if (wr_b0) begin
                     if (r_reg.w_data[fcs_pkg::STAT_PVIOL]) begin
                        r_next.pviol = 1'b0;
                     end
                     if (r_reg.w_data[fcs_pkg::STAT_ACCERR]) begin
                        r_next.accerr = 1'b0;
                     end
                     launch_try = r_reg.w_data[fcs_pkg::STAT_CBEF] & r_reg.buf_empty;
                  end
               end
               fcs_pkg::OFF_CMD: begin
                  if (wr_b0 && r_reg.buf_empty) begin
                     if (r_reg.seq == fcs_pkg::FCS_SEQ_DATA) begin
                        r_next.cmd = r_reg.w_data[7:0];
                        r_next.seq = fcs_pkg::FCS_SEQ_CMD;
                     end else begin
                        set_acc = 1'b1;
                        r_next.seq = fcs_pkg::FCS_SEQ_IDLE;
                     end
                  end
               end
               fcs_pkg::OFF_FADDR: begin
                  if (r_reg.w_strb[0]) begin
                     r_next.fl_addr[7:0] = r_reg.w_data[7:0];
                  end
                  if (r_reg.w_strb[1]) begin
                     r_next.fl_addr[15:8] = r_reg.w_data[15:8];
                  end
               end
               fcs_pkg::OFF_FDATA: begin
                  if (wr_b0 && r_reg.key_acc && in_key_range) begin
                     key_we = ~r_reg.aw_nsec;
                  end else if (wr_b0 && r_reg.buf_empty) begin
                     if (r_reg.seq == fcs_pkg::FCS_SEQ_IDLE) begin
                        r_next.fl_data = r_reg.w_data[7:0];
                        r_next.seq = fcs_pkg::FCS_SEQ_DATA;
                     end else begin
                        set_acc = 1'b1;
                        r_next.seq = fcs_pkg::FCS_SEQ_IDLE;
                     end
                  end
               end
               fcs_pkg::OFF_OPT, fcs_pkg::OFF_PROT: begin
                  r_next.bresp = fcs_pkg::RESP_OKAY;
               end
               default: begin
                  r_next.bresp = fcs_pkg::RESP_SLVERR;
               end
            endcase
         end
         if (launch_try) begin
            r_next.seq = fcs_pkg::FCS_SEQ_IDLE;
            if (r_reg.seq != fcs_pkg::FCS_SEQ_CMD || !cmd_valid || !r_reg.ratio_written) begin
               set_acc = 1'b1;
            end else if (r_reg.running && (r_reg.cmd != fcs_pkg::CMD_BURST_PROG ||
                         r_reg.run_cmd != fcs_pkg::CMD_BURST_PROG)) begin
               set_acc = 1'b1;
            end else if (cmd_prot) begin
               set_pv = 1'b1;
            end else begin
               launch_ok = 1'b1;
               r_next.buf_empty = 1'b0;
               r_next.blank = 1'b0;
            end
         end
         // Burst commands wait here while the array finishes the previous one.
         if (!r_reg.buf_empty && !r_reg.running) begin
            r_next.start = 1'b1;
            r_next.running = 1'b1;
            r_next.run_cmd = r_reg.cmd;
            r_next.a_cmd = r_reg.cmd;
            r_next.a_addr = r_reg.fl_addr;
            r_next.a_data = r_reg.fl_data;
            r_next.buf_empty = 1'b1;
         end
         if (array_done && r_reg.running) begin
            r_next.running = 1'b0;
            done_blank = (r_reg.run_cmd == fcs_pkg::CMD_BLANK) & array_blank;
         end
         if (stop_entry && (r_reg.running || !r_reg.buf_empty)) begin
            set_acc = 1'b1;
            r_next.running = 1'b0;
            r_next.buf_empty = 1'b1;
         end
         if (done_blank) begin
            r_next.blank = 1'b1;
         end
         if (done_blank || key_unlock) begin
            r_next.opt[1:0] = fcs_pkg::SEC_UNSECURED;
         end
         if (set_acc) begin
            r_next.accerr = 1'b1;
         end
         if (set_pv) begin
            r_next.pviol = 1'b1;
         end
         // Only the debug port reaches protection; bus writes never land here.
         if (dbg_prot_we) begin
            r_next.prot = dbg_prot_data;
         end
         if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = fcs_pkg::RESP_OKAY;
            case (s_axi_araddr)
               fcs_pkg::OFF_RATIO: r_next.rdata = {r_reg.ratio_written, r_reg.ratio};
               fcs_pkg::OFF_OPT: r_next.rdata = r_reg.opt;
               fcs_pkg::OFF_CNFG: r_next.rdata = {2'b00, r_reg.key_acc, 5'b00000};
               fcs_pkg::OFF_PROT: r_next.rdata = r_reg.prot;
               fcs_pkg::OFF_STAT: r_next.rdata = st_byte;
               fcs_pkg::OFF_CMD: r_next.rdata = r_reg.cmd;
               fcs_pkg::OFF_FADDR: r_next.rdata = r_reg.fl_addr[7:0];
               fcs_pkg::OFF_FDATA: r_next.rdata = r_reg.fl_data;
               default: begin
                  r_next.rdata = 8'h00;
                  r_next.rresp = fcs_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      r_reg <= r_next;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready = ~r_reg.aw_held & ~r_reg.bvalid;
   assign s_axi_wready = ~r_reg.w_held & ~r_reg.bvalid;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = ~r_reg.rvalid;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rresp = r_reg.rresp;
   assign s_axi_rdata = {24'h000000, r_reg.rdata};
   assign array_start = r_reg.start;
   assign array_cmd = r_reg.a_cmd;
   assign array_addr = r_reg.a_addr;
   assign array_data = r_reg.a_data;
   assign array_tick_ratio = r_reg.ratio;
   assign device_secure = (r_reg.opt[1:0] != fcs_pkg::SEC_UNSECURED);
   assign vector_redirect_enable = ~r_reg.opt[fcs_pkg::OPT_NORED];
   assign mem_access_deny = device_secure & mem_req_unsecured;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_opt_reset_load: assert property ($rose(aresetn) |-> r_reg.opt == $past(nonvolatile_options_copy)) else $error("options not reloaded");
   a_key_needs_enable: assert property (key_unlock |-> r_reg.opt[fcs_pkg::OPT_KEY_EN] && key_match) else $error("key unlock without enable");
   a_key_secure_only: assert property (key_we |-> !r_reg.aw_nsec && r_reg.key_acc) else $error("key byte from unsecured source");
   a_unlock_sets_code: assert property ((key_unlock || done_blank) |=> !device_secure) else $error("security not released");
   a_redirect_bit: assert property (vector_redirect_enable != r_reg.opt[fcs_pkg::OPT_NORED]) else $error("redirect mismatch");
   a_deny_secure: assert property (mem_req_unsecured && device_secure |-> mem_access_deny) else $error("unsecured access let through");
   a_prot_bus_ro: assert property (wr_go && r_reg.aw_addr == fcs_pkg::OFF_PROT && !dbg_prot_we |=> $stable(r_reg.prot)) else $error("protection changed by bus");
   a_pviol_ignored: assert property (set_pv && !set_acc |=> r_reg.pviol && r_reg.buf_empty && !r_reg.start) else $error("protected command not refused");
   a_bad_code_err: assert property (launch_try && r_reg.seq == fcs_pkg::FCS_SEQ_CMD && !cmd_valid |=> r_reg.accerr ##1 !r_reg.start) else $error("bad code accepted");
   a_ratio_gate: assert property (launch_ok |-> r_reg.ratio_written) else $error("launch before ratio written");
   a_launch_ccf: assert property (launch_ok && !r_reg.running |=> !ccf ##1 r_reg.start) else $error("launch did not start array");
   a_blank_flag: assert property (done_blank |=> r_reg.blank && st_byte[fcs_pkg::STAT_BLANK]) else $error("blank flag not set");
endmodule
`default_nettype wire

// file: sim/fcs_flash_ctrl_tb_top.sv
// Self-checking testbench of the flash command and security controller.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, nv_opt = 8'hC0, dbg_data = 8'h00, rnd = 8'h1C;
   logic [2:0] awprot = 3'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, dbg_we = 0, mreq = 0;
   logic adone = 0, ablank = 0, hold = 0, stop = 0;
   logic [31:0] wdata = 32'h0, cap = 32'h0;
   logic [63:0] key = 64'h0123456789ABCDEF;
   logic [7:0] codes [4] = '{8'h05, 8'h20, 8'h25, 8'h40};
   logic [1:0] lresp = 2'h0, lrresp = 2'h0;
   wire logic awready, wready, bvalid, arready, rvalid, astart, secure, vre, deny;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0] acmd, adata;
   wire logic [15:0] aaddr;
   wire logic [6:0] ratio;
   logic [31:0] q [$];
   int err_count = 0, tests_run = 0, starts = 0;
   always #10 aclk = ~aclk;
   fcs_flash_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .nonvolatile_options_copy(nv_opt),
      .nonvolatile_protection_copy(8'h80), .backdoor_key_locations(key),
      .dbg_prot_we(dbg_we), .dbg_prot_data(dbg_data), .mem_req_unsecured(mreq),
      .array_done(adone), .array_blank(ablank), .stop_entry(stop), .array_start(astart),
      .array_cmd(acmd), .array_addr(aaddr), .array_data(adata), .array_tick_ratio(ratio),
      .device_secure(secure), .vector_redirect_enable(vre), .mem_access_deny(deny));
   // ********************************************
   // Bus tasks and comparison
   // ********************************************
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data is judged here, so a late answer still meets its own note.
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         lrresp = rresp;
         chk(rdata, q.pop_front());
      end
   end
   always @(posedge aclk) begin
      if (astart) begin
         starts++;
         cap = {acmd, aaddr, adata};
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         lresp = bresp;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic cmd(input logic [15:0] a, input logic [7:0] c, input logic go, input logic b);
      int k;
      rnd = lfsr(rnd);
      wr(fcs_pkg::OFF_FADDR, {16'h0, a});
      wr(fcs_pkg::OFF_FDATA, {24'h0, rnd});
      wr(fcs_pkg::OFF_CMD, {24'h0, c});
      k = starts;
      wr(fcs_pkg::OFF_STAT, 32'h80);
      repeat (6) @(posedge aclk);
      chk(32'(starts - k), {31'h0, go});
      if (go) begin
         chk(cap, {c, a, rnd});
         adone <= !hold;
         ablank <= b;
         @(posedge aclk);
         adone <= 1'b0;
         @(posedge aclk);
      end
   endtask
   task automatic keyrun(input logic [2:0] p);
      wr(fcs_pkg::OFF_CNFG, 32'h20);
      awprot <= p;
      for (int k = 0; k < 8; k++) begin
         wr(fcs_pkg::OFF_FADDR, 32'hFFB0 + k);
         wr(fcs_pkg::OFF_FDATA, {24'h0, key[8*k +: 8]});
      end
      awprot <= 3'h0;
      wr(fcs_pkg::OFF_CNFG, 32'h00);
   endtask
   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic note(input string s);
      $display("test %s done at %0t", s, $time);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ********************************************
   // Main sequence and watchdog
   // ********************************************
   // The tests need well under ten thousand cycles; a hang is cut off long after.
   initial begin
      repeat (40000) @(posedge aclk);
      err_count++;
      stop_test;
   end
   initial begin
      do_reset;
      mreq <= 1'b1;
      rd(fcs_pkg::OFF_OPT, 32'hC0);
      rd(fcs_pkg::OFF_PROT, 32'h80);
      rd(fcs_pkg::OFF_STAT, 32'hC0);
      chk({29'h0, secure, vre, deny}, 32'h5);
      keyrun(3'h2);
      chk({31'h0, secure}, 32'h1);
      keyrun(3'h0);
      chk({29'h0, secure, vre, deny}, 32'h0);
      rd(fcs_pkg::OFF_OPT, 32'hC2);
      note("key");
      nv_opt <= 8'h03;
      do_reset;
      rd(fcs_pkg::OFF_OPT, 32'h03);
      keyrun(3'h0);
      chk({29'h0, secure, vre, deny}, 32'h7);
      cmd(16'h8000, fcs_pkg::CMD_BYTE_PROG, 1'b0, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'hD0);
      wr(fcs_pkg::OFF_STAT, 32'h10);
      rnd = lfsr(rnd);
      wr(fcs_pkg::OFF_RATIO, {25'h0, rnd[6:0]});
      chk({30'h0, lresp}, {30'h0, fcs_pkg::RESP_OKAY});
      rd(fcs_pkg::OFF_RATIO, {24'h0, 1'b1, rnd[6:0]});
      chk({30'h0, lrresp}, {30'h0, fcs_pkg::RESP_OKAY});
      chk({25'h0, ratio}, {25'h0, rnd[6:0]});
      wr(8'h24, 32'h0);
      chk({30'h0, lresp}, {30'h0, fcs_pkg::RESP_SLVERR});
      rd(8'h20, 32'h0);
      chk({30'h0, lrresp}, {30'h0, fcs_pkg::RESP_SLVERR});
      note("ratio");
      for (int i = 0; i < 4; i++) begin
         cmd(16'h8000, codes[i], 1'b1, 1'b0);
         rd(fcs_pkg::OFF_STAT, 32'hC0);
      end
      cmd(16'h8200, fcs_pkg::CMD_PAGE_ERASE, 1'b0, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'hE0);
      wr(fcs_pkg::OFF_STAT, 32'h20);
      cmd(16'h8000, fcs_pkg::CMD_MASS_ERASE, 1'b0, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'hE0);
      wr(fcs_pkg::OFF_STAT, 32'h20);
      cmd(16'h8000, 8'h33, 1'b0, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'hD0);
      wr(fcs_pkg::OFF_STAT, 32'h10);
      rd(fcs_pkg::OFF_STAT, 32'hC0);
      note("errors");
      wr(fcs_pkg::OFF_PROT, 32'h01);
      rd(fcs_pkg::OFF_PROT, 32'h80);
      dbg_data <= 8'h01;
      dbg_we <= 1'b1;
      @(posedge aclk);
      dbg_we <= 1'b0;
      rd(fcs_pkg::OFF_PROT, 32'h01);
      cmd(16'h8200, fcs_pkg::CMD_MASS_ERASE, 1'b1, 1'b0);
      cmd(16'hFE00, fcs_pkg::CMD_BLANK, 1'b1, 1'b1);
      rd(fcs_pkg::OFF_STAT, 32'hC4);
      chk({30'h0, secure, deny}, 32'h0);
      rd(fcs_pkg::OFF_OPT, 32'h02);
      cmd(16'h8000, fcs_pkg::CMD_BYTE_PROG, 1'b1, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'hC0);
      note("commands");
      // The array is left busy so that a second burst must wait in the buffer.
      hold = 1'b1;
      cmd(16'h8000, fcs_pkg::CMD_BURST_PROG, 1'b1, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'h80);
      cmd(16'h8001, fcs_pkg::CMD_BURST_PROG, 1'b0, 1'b0);
      rd(fcs_pkg::OFF_STAT, 32'h00);
      stop <= 1'b1;
      @(posedge aclk);
      stop <= 1'b0;
      rd(fcs_pkg::OFF_STAT, 32'hD0);
      note("burst");
      stop_test;
   end
endmodule
`default_nettype wire
